// ### src/spm_pkg.sv
// shared constants and types for the shared-pin priority multiplexer
// assumes: one system clock, synchronous active-low system reset
package spm_pkg;

   // number of shared port-a pins and special-function slots per pin
   localparam int SPM_PINS  = 6;
   localparam int SPM_SLOTS = 3;

   // ownership level of a pin; slot 0 is the highest priority function
   typedef logic [1:0] spm_lvl_t;

   localparam spm_lvl_t SPM_LVL_SLOT0 = 2'h0;
   localparam spm_lvl_t SPM_LVL_SLOT1 = 2'h1;
   localparam spm_lvl_t SPM_LVL_SLOT2 = 2'h2;
   localparam spm_lvl_t SPM_LVL_GPIO  = 2'h3;

   // values after reset: every pin is a plain input owned by the port
   localparam spm_lvl_t    SPM_RST_OWNER = SPM_LVL_GPIO;
   localparam logic        SPM_RST_OE    = 1'h0;
   localparam logic        SPM_RST_OUT   = 1'h0;

   // idle level returned to a function that does not own its pin,
   // bit index is pin*3+slot; external interrupt and reset are active low
   localparam logic [17:0] SPM_IDLE_HI   = 18'h00240;

   // pin index of the input-only port bit
   localparam int SPM_INPUT_ONLY_PIN = 2;

endpackage

// ### src/spm_pin_if.sv
// per-pin connection between the main mux and its priority arbiter
// assumes: spm_pkg compiled first; purely combinational signals
`timescale 1ns/100ps

interface spm_pin_if;
   import spm_pkg::*;

   logic [2:0] en;        // function enables, bit 0 highest priority
   logic [2:0] f_out;     // function output data
   logic [2:0] f_oe;      // function output enables
   logic       gpio_out;  // port data
   logic       gpio_oe;   // port direction, high drives
   spm_lvl_t   owner;     // winning level
   logic       pad_out;   // resolved pad data
   logic       pad_oe;    // resolved pad enable

   modport arb (
      input  en, f_out, f_oe, gpio_out, gpio_oe,
      output owner, pad_out, pad_oe
   );
   modport mux (
      output en, f_out, f_oe, gpio_out, gpio_oe,
      input  owner, pad_out, pad_oe
   );
endinterface

// ### src/spm_pin_arbiter.sv
// fixed-priority resolver for one shared pin
// assumes: caller registers the result and applies reset itself
`timescale 1ns/100ps

module spm_pin_arbiter (
   spm_pin_if.arb pin     // one pin's enables in, owner and drive out
);
   import spm_pkg::*;

   // highest enabled slot wins, port function only when none enabled
   always_comb begin
      if (pin.en[0]) begin
         pin.owner   = SPM_LVL_SLOT0;
         pin.pad_out = pin.f_out[0];
         pin.pad_oe  = pin.f_oe[0];
      end else if (pin.en[1]) begin
         pin.owner   = SPM_LVL_SLOT1;
         pin.pad_out = pin.f_out[1];
         pin.pad_oe  = pin.f_oe[1];
      end else if (pin.en[2]) begin
         pin.owner   = SPM_LVL_SLOT2;
         pin.pad_out = pin.f_out[2];
         pin.pad_oe  = pin.f_oe[2];
      end else begin
         pin.owner   = SPM_LVL_GPIO;
         pin.pad_out = pin.gpio_out;
         pin.pad_oe  = pin.gpio_oe;
      end
   end

endmodule

// ### src/spm_pin_mux.sv
// shared port-a pin priority multiplexer, six pins
// assumes: peripherals give enables synchronous to clock_i; pads
// resolve the wire from pad_out_o/pad_oe_o; pad_in_i is synchronous
`timescale 1ns/100ps

// Overview of operation
// - while reset is held every pin is an undriven input owned by the port
// - bit 0 priority: analog ch0, timer chan 0, key wake 0, then port
// - bit 1 priority: analog ch1, timer chan 1, key wake 1, then port
// - bit 2 priority: ext interrupt, key wake 2, timer clock, input-only port
// - bit 4 priority: oscillator out, analog ch2, key wake 4, then port
// - bit 5 priority: oscillator in, analog ch3, key wake 5, then port
module spm_pin_mux (
   input  wire logic                 clock_i,          // system clock, 100 MHz
   input  wire logic                 rst_n_i,          // synchronous reset, active low
   input  wire logic [3:0]           adc_en_i,         // analog_in_ch0..3 enabled
   input  wire logic [1:0]           tim_en_i,         // timer_chan_0..1 enabled
   input  wire logic [1:0]           tim_out_i,        // timer channel output data
   input  wire logic [1:0]           tim_oe_i,         // timer channel drives pin
   input  wire logic [5:0]           kbi_en_i,         // key_wake_in_0..5 enabled
   input  wire logic                 irq_en_i,         // ext_int_in enabled
   input  wire logic                 timer_ext_clk_in_en_i,        // timer_ext_clk_in enabled
   input  wire logic                 rst_pin_en_i,     // reset_pin_in enabled
   input  wire logic                 osc_out_en_i,     // osc_out_pin enabled
   input  wire logic                 osc_out_i,        // oscillator output level
   input  wire logic                 osc_in_en_i,      // osc_in_pin enabled
   input  wire logic [5:0]           gpio_out_i,       // port data register
   input  wire logic [5:0]           gpio_dir_i,       // port direction, 1 = out
   input  wire logic [5:0]           pad_in_i,         // pad input levels
   output logic      [5:0]           pad_out_o,        // pad output data
   output logic      [5:0]           pad_oe_o,         // pad output enable
   output spm_pkg::spm_lvl_t [5:0]   owner_o,          // current owner level per pin
   output logic      [5:0]           gpio_in_o,        // port input data
   output logic      [5:0]           kbi_in_o,         // key wake input levels
   output logic      [3:0]           adc_sel_o,        // analog channel owns its pin
   output logic      [1:0]           tim_in_o,         // timer channel input levels
   output logic                      irq_in_n_o,       // ext interrupt level, low active
   output logic                      timer_ext_clk_in_o,           // timer external clock level
   output logic                      rst_pin_n_o,      // reset pin level, low active
   output logic                      osc_in_o          // oscillator input level
);
   import spm_pkg::*;

   // per-pin slot vectors, bit 0 is the highest priority function
   logic [2:0]     en_v   [SPM_PINS];
   logic [2:0]     out_v  [SPM_PINS];
   logic [2:0]     oe_v   [SPM_PINS];
   logic [5:0]     gdir_v;

   // registered pad drive, owner and routed inputs
   logic [5:0]     pad_out_r;
   logic [5:0]     pad_oe_r;
   spm_lvl_t [5:0] owner_r;
   logic [2:0]     fn_in_r [SPM_PINS];
   logic [5:0]     gpio_in_r;

   spm_pin_if pin_if [SPM_PINS] ();

   // bit 0: analog, timer, key wake; timer is the only driving function
   assign en_v[0]  = {kbi_en_i[0], tim_en_i[0], adc_en_i[0]};
   assign out_v[0] = {1'b0, tim_out_i[0], 1'b0};
   assign oe_v[0]  = {1'b0, tim_oe_i[0], 1'b0};

   // bit 1: same arrangement as bit 0 on the second channels
   assign en_v[1]  = {kbi_en_i[1], tim_en_i[1], adc_en_i[1]};
   assign out_v[1] = {1'b0, tim_out_i[1], 1'b0};
   assign oe_v[1]  = {1'b0, tim_oe_i[1], 1'b0};

   // bit 2: all functions are inputs, so nothing ever drives this pad
   assign en_v[2]  = {timer_ext_clk_in_en_i, kbi_en_i[2], irq_en_i};
   assign out_v[2] = 3'h0;
   assign oe_v[2]  = 3'h0;

   // bit 3: only two special functions, third slot never enabled
   assign en_v[3]  = {1'b0, kbi_en_i[3], rst_pin_en_i};
   assign out_v[3] = 3'h0;
   assign oe_v[3]  = 3'h0;

   // bit 4: oscillator output drives whenever it owns the pin
   assign en_v[4]  = {kbi_en_i[4], adc_en_i[2], osc_out_en_i};
   assign out_v[4] = {1'b0, 1'b0, osc_out_i};
   assign oe_v[4]  = 3'h1;

   // bit 5: oscillator input wins over analog and key wake
   assign en_v[5]  = {kbi_en_i[5], adc_en_i[3], osc_in_en_i};
   assign out_v[5] = 3'h0;
   assign oe_v[5]  = 3'h0;

   // port direction; the input-only bit can never be turned to an output
   always_comb begin
      gdir_v                     = gpio_dir_i;
      gdir_v[SPM_INPUT_ONLY_PIN] = 1'b0;
   end

   genvar g;
   generate
      for (g = 0; g < SPM_PINS; g++) begin : g_pin
         // hand this pin's candidates to its resolver
         assign pin_if[g].en       = en_v[g];
         assign pin_if[g].f_out    = out_v[g];
         assign pin_if[g].f_oe     = oe_v[g];
         assign pin_if[g].gpio_out = gpio_out_i[g];
         assign pin_if[g].gpio_oe  = gdir_v[g];

         spm_pin_arbiter u_arb (
            .pin (pin_if[g].arb)
         );

         // pad drive and owner; reset forces a plain undriven input
         always_ff @(posedge clock_i) begin
            if (!rst_n_i) begin
               pad_out_r[g] <= SPM_RST_OUT;
               pad_oe_r[g]  <= SPM_RST_OE;
               owner_r[g]   <= SPM_RST_OWNER;
            end else begin
               pad_out_r[g] <= pin_if[g].pad_out;
               pad_oe_r[g]  <= pin_if[g].pad_oe;
               owner_r[g]   <= pin_if[g].owner;
            end
         end

         // route the pad level only to the function that owns the pin,
         // losers see their idle level so they cannot false-trigger
         for (genvar s = 0; s < SPM_SLOTS; s++) begin : g_slot
            always_ff @(posedge clock_i) begin
               if (!rst_n_i) begin
                  fn_in_r[g][s] <= SPM_IDLE_HI[g*SPM_SLOTS+s];
               end else if (pin_if[g].owner == spm_lvl_t'(s)) begin
                  fn_in_r[g][s] <= pad_in_i[g];
               end else begin
                  fn_in_r[g][s] <= SPM_IDLE_HI[g*SPM_SLOTS+s];
               end
            end
         end
      end
   endgenerate

   // port input data follows the pad on every pin, as a port read would
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         gpio_in_r <= 6'h00;
      end else begin
         gpio_in_r <= pad_in_i;
      end
   end

   // pad side and owner report
   assign pad_out_o = pad_out_r;
   assign pad_oe_o  = pad_oe_r;
   assign owner_o   = owner_r;
   assign gpio_in_o = gpio_in_r;

   // function inputs gathered from their pin slots
   assign kbi_in_o    = {fn_in_r[5][2], fn_in_r[4][2], fn_in_r[3][1],
                         fn_in_r[2][1], fn_in_r[1][2], fn_in_r[0][2]};
   assign tim_in_o    = {fn_in_r[1][1], fn_in_r[0][1]};
   assign irq_in_n_o  = fn_in_r[2][0];
   assign timer_ext_clk_in_o      = fn_in_r[2][2];
   assign rst_pin_n_o = fn_in_r[3][0];
   assign osc_in_o    = fn_in_r[5][0];

   // analog switch select: the channel really owns its pin
   assign adc_sel_o = {owner_r[5] == SPM_LVL_SLOT1, owner_r[4] == SPM_LVL_SLOT1,
                       owner_r[1] == SPM_LVL_SLOT0, owner_r[0] == SPM_LVL_SLOT0};

endmodule

// ### testbench/spm_pin_mux_asserts.sv
// port checker for the shared-pin priority mux
// assumes: bound onto spm_pin_mux, one clock domain
`timescale 1ns/100ps
module spm_pin_mux_asserts
   import spm_pkg::*;
(
   input wire logic             clock_i, rst_n_i,                // clock, reset
   input wire logic [3:0]       adc_en_i, adc_sel_o,             // analog
   input wire logic [1:0]       tim_en_i, tim_oe_i,              // timer
   input wire logic [5:0]       kbi_en_i, gpio_out_i, gpio_dir_i, // port side
   input wire logic [5:0]       pad_in_i, pad_out_o, pad_oe_o,   // pads
   input wire logic             irq_en_i, rst_pin_en_i, osc_in_o, // misc
   input wire logic             timer_ext_clk_in_en_i, osc_out_en_i, osc_out_i, osc_in_en_i, // misc
   input wire spm_lvl_t [5:0]   owner_o                          // owners
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // reset seen at the previous edge; starts clear
   logic in_rst_r = 1'b0;
   always_ff @(posedge clock_i) in_rst_r <= !rst_n_i;
   sequence s_tim0; !adc_en_i[0] && tim_en_i[0]; endsequence
   sequence s_none1; !adc_en_i[1] && !tim_en_i[1] && !kbi_en_i[1]; endsequence
   sequence s_tclk2; !irq_en_i && !kbi_en_i[2] && timer_ext_clk_in_en_i; endsequence
   chk_reset_idle: assert property (in_rst_r |-> pad_oe_o == 6'h00 && owner_o == 12'hFFF)
      else $error("pins not idle after reset");
   chk_adc0_wins: assert property (adc_en_i[0] |=> owner_o[0] == SPM_LVL_SLOT0 && adc_sel_o[0])
      else $error("analog ch0 lost pin 0");
   chk_tim0_drive: assert property (s_tim0 |=> owner_o[0] == SPM_LVL_SLOT1 && pad_oe_o[0] == $past(tim_oe_i[0]))
      else $error("timer 0 drive wrong");
   chk_key_wake_in_1_owns: assert property (!adc_en_i[1] && !tim_en_i[1] && kbi_en_i[1] |=> owner_o[1] == SPM_LVL_SLOT2)
      else $error("key wake 1 lost pin 1");
   chk_irq_owns: assert property (irq_en_i |=> owner_o[2] == SPM_LVL_SLOT0 && !pad_oe_o[2])
      else $error("interrupt lost pin 2");
   chk_rstpin_owns: assert property (rst_pin_en_i |=> owner_o[3] == SPM_LVL_SLOT0 && !pad_oe_o[3])
      else $error("reset pin lost pin 3");
   chk_oscout_drive: assert property (osc_out_en_i |=> pad_oe_o[4] && pad_out_o[4] == $past(osc_out_i))
      else $error("osc out not driven");
   chk_oscin_owns: assert property (osc_in_en_i |=> !adc_sel_o[3] && osc_in_o == $past(pad_in_i[5]))
      else $error("osc in lost pin 5");
   chk_port_fallback: assert property (s_none1 |=> owner_o[1] == SPM_LVL_GPIO && pad_oe_o[1] == $past(gpio_dir_i[1])
      && pad_out_o[1] == $past(gpio_out_i[1]))
      else $error("port fallback wrong");
   chk_timer_ext_clk_in_owns: assert property (s_tclk2 |=> owner_o[2] == SPM_LVL_SLOT2 && !pad_oe_o[2])
      else $error("timer clock lost pin 2");
   chk_pin2_input: assert property (pad_oe_o[2] == 1'b0)
      else $error("input-only pin driven");
endmodule

bind spm_pin_mux spm_pin_mux_asserts spm_pin_mux_asserts_i (.clock_i, .rst_n_i, .adc_en_i, .adc_sel_o,
   .tim_en_i, .tim_oe_i, .kbi_en_i, .gpio_out_i, .gpio_dir_i, .pad_in_i, .pad_out_o, .pad_oe_o, .irq_en_i,
   .rst_pin_en_i, .osc_in_o, .timer_ext_clk_in_en_i, .osc_out_en_i, .osc_out_i, .osc_in_en_i, .owner_o);

// ### testbench/spm_pad_model.sv
// pad ring stand-in: resolves each shared pin level
// assumes: device drive wins over the board
`timescale 1ns/100ps
module spm_pad_model (
   input  wire logic [5:0] pad_out_i, // device data
   input  wire logic [5:0] pad_oe_i,  // device drives
   input  wire logic [5:0] ext_val_i, // board level
   input  wire logic [5:0] ext_en_i,  // board drives
   output logic      [5:0] pad_lvl_o  // wire level
);
   // undriven pins float up to the pull-up, never hold
   always_comb begin
      for (int k = 0; k < 6; k++) begin
         pad_lvl_o[k] = pad_oe_i[k] ? pad_out_i[k] : (ext_en_i[k] ? ext_val_i[k] : 1'b1);
      end
   end
endmodule

// ### testbench/spm_pin_mux_bench.sv
// random and corner stimulus for the shared-pin mux
// assumes: spm_pkg, pad model and checker compiled first
`timescale 1ns/100ps
module spm_pin_mux_bench;
   import spm_pkg::*;
   logic           clock_i = 1'b0, rst_n_i = 1'b0, irq_en_i = 1'b0, timer_ext_clk_in_en_i = 1'b0, rst_pin_en_i = 1'b0;
   logic           osc_out_en_i = 1'b0, osc_out_i = 1'b0, osc_in_en_i = 1'b0;
   logic [3:0]     adc_en_i = 4'h0, adc_sel_o;
   logic [1:0]     tim_en_i = 2'h0, tim_out_i = 2'h0, tim_oe_i = 2'h0, tim_in_o;
   logic [5:0]     kbi_en_i = 6'h00, gpio_out_i = 6'h00, gpio_dir_i = 6'h00, ext_val = 6'h00, ext_en = 6'h00;
   logic [5:0]     pad_in_i, pad_out_o, pad_oe_o, gpio_in_o, kbi_in_o, exp_oe, exp_out, exp_gin, exp_kbi;
   logic           irq_in_n_o, timer_ext_clk_in_o, rst_pin_n_o, osc_in_o, exp_irq;
   logic [4:0]     exp_fin;
   logic [3:0]     exp_adc;
   spm_lvl_t [5:0] owner_o, exp_own;
   int             err_total = 0, cmp_count = 0;
   always #5 clock_i = ~clock_i;
   spm_pin_mux spm_pin_mux_i (.clock_i, .rst_n_i, .adc_en_i, .tim_en_i, .tim_out_i, .tim_oe_i, .kbi_en_i,
      .irq_en_i, .timer_ext_clk_in_en_i, .rst_pin_en_i, .osc_out_en_i, .osc_out_i, .osc_in_en_i, .gpio_out_i, .gpio_dir_i,
      .pad_in_i, .pad_out_o, .pad_oe_o, .owner_o, .gpio_in_o, .kbi_in_o, .adc_sel_o, .tim_in_o, .irq_in_n_o,
      .timer_ext_clk_in_o, .rst_pin_n_o, .osc_in_o);
   spm_pad_model spm_pad_model_i (.pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .ext_val_i(ext_val),
      .ext_en_i(ext_en), .pad_lvl_o(pad_in_i));
   // first enabled slot wins, none leaves the port
   function automatic spm_lvl_t lvl(input logic [2:0] e);
      lvl = e[0] ? SPM_LVL_SLOT0 : e[1] ? SPM_LVL_SLOT1 : e[2] ? SPM_LVL_SLOT2 : SPM_LVL_GPIO;
   endfunction
   task automatic check(input logic [11:0] a, input logic [11:0] b, input string what);
      cmp_count++;
      if (a !== b) begin
         err_total++;
         $display("unexpected at %0t: %s mismatch", $time, what);
      end
   endtask
   // expected state one edge after the current inputs
   task automatic predict;
      logic [2:0] e [6];
      e = '{{kbi_en_i[0], tim_en_i[0], adc_en_i[0]}, {kbi_en_i[1], tim_en_i[1], adc_en_i[1]},
            {timer_ext_clk_in_en_i, kbi_en_i[2], irq_en_i}, {1'b0, kbi_en_i[3], rst_pin_en_i},
            {kbi_en_i[4], adc_en_i[2], osc_out_en_i}, {kbi_en_i[5], adc_en_i[3], osc_in_en_i}};
      for (int k = 0; k < 6; k++) begin
         exp_own[k] = rst_n_i ? lvl(e[k]) : SPM_RST_OWNER;
         exp_oe[k] = exp_own[k] == SPM_LVL_GPIO && gpio_dir_i[k] && k != SPM_INPUT_ONLY_PIN && rst_n_i;
         exp_out[k] = gpio_out_i[k];
         if (k < 2 && exp_own[k] == SPM_LVL_SLOT1) begin
            exp_oe[k] = tim_oe_i[k];
            exp_out[k] = tim_out_i[k];
         end
         exp_kbi[k] = exp_own[k] == (k inside {2, 3} ? SPM_LVL_SLOT1 : SPM_LVL_SLOT2) && pad_in_i[k];
      end
      if (exp_own[4] == SPM_LVL_SLOT0) begin
         exp_oe[4] = 1'b1;
         exp_out[4] = osc_out_i;
      end
      exp_irq = !(exp_own[2] == SPM_LVL_SLOT0 && !pad_in_i[2]);
      // timer inputs, timer clock, reset pin (idle high), oscillator input
      exp_fin = {exp_own[1] == SPM_LVL_SLOT1 && pad_in_i[1], exp_own[0] == SPM_LVL_SLOT1 && pad_in_i[0],
                 exp_own[2] == SPM_LVL_SLOT2 && pad_in_i[2], !(exp_own[3] == SPM_LVL_SLOT0 && !pad_in_i[3]),
                 exp_own[5] == SPM_LVL_SLOT0 && pad_in_i[5]};
      // analog channel n owns its pin: ch0/ch1 at slot 0, ch2/ch3 at slot 1
      exp_adc = {exp_own[5] == SPM_LVL_SLOT1, exp_own[4] == SPM_LVL_SLOT1, exp_own[1] == SPM_LVL_SLOT0,
                 exp_own[0] == SPM_LVL_SLOT0};
      exp_gin = rst_n_i ? pad_in_i : 6'h00;
   endtask
   task automatic give_verdict;
      if (err_total == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // sparse enables reach the lower slots; all-on (oscillator enables left random) and mid-run reset are corners
   initial begin
      void'($urandom(32'h3d6b));
      for (int n = 0; n < 600; n++) begin
         @(posedge clock_i);
         #1;
         if (n > 0) begin
            check(owner_o, exp_own, "owner");
            check(12'(pad_oe_o), 12'(exp_oe), "drive enable");
            check(12'(pad_out_o & exp_oe), 12'(exp_out & exp_oe), "pad data");
            check(12'(kbi_in_o), 12'(exp_kbi), "key wake level");
            check(12'(irq_in_n_o), 12'(exp_irq), "interrupt level");
            check(12'(gpio_in_o), 12'(exp_gin), "port input");
            check(12'({tim_in_o, timer_ext_clk_in_o, rst_pin_n_o, osc_in_o}), 12'(exp_fin), "function level");
            check(12'(adc_sel_o), 12'(exp_adc), "analog select");
         end
         rst_n_i = !(n < 2 || n == 300 || n == 301);
         {adc_en_i, tim_en_i, kbi_en_i, irq_en_i, timer_ext_clk_in_en_i, rst_pin_en_i, osc_out_en_i, osc_in_en_i} =
            17'($urandom & $urandom);
         if (n % 100 == 99) {adc_en_i, tim_en_i, kbi_en_i, irq_en_i, timer_ext_clk_in_en_i, rst_pin_en_i} = '1;
         {tim_out_i, tim_oe_i, osc_out_i, gpio_out_i, gpio_dir_i, ext_val} = 23'($urandom);
         ext_en = 6'($urandom) & ~pad_oe_o;
         #1 predict();
      end
      give_verdict();
   end
endmodule
